// file: src/flash_prot_pkg.sv
// shared constants for the flash sector protection block
package flash_prot_pkg;

  // register indices as printed, byte address is four times the index
  localparam logic [7:0] IDX_PROT = 8'h04;
  localparam logic [7:0] IDX_STAT = 8'h05;
  localparam logic [7:0] IDX_BANK = 8'h06;
  localparam logic [7:0] IDX_EVT_STAT = 8'h08;
  localparam logic [7:0] IDX_EVT_CLR = 8'h09;
  localparam logic [7:0] IDX_EVT_EN = 8'h0a;

  // protection register field positions
  localparam int POS_FUNC = 7;
  localparam int POS_RSV = 6;
  localparam int POS_HDIS = 5;
  localparam int POS_HS_HI = 4;
  localparam int POS_HS_LO = 3;
  localparam int POS_LDIS = 2;
  localparam int POS_LS_HI = 1;
  localparam int POS_LS_LO = 0;

  // status register field position of the violation flag
  localparam int POS_VIOL = 5;

  // event status layout: violation per block, refused mass erase per block
  localparam int EVT_W = 4;
  localparam int EVT_VIOL0 = 0;
  localparam int EVT_MASS0 = 2;

  // reset values
  localparam logic [7:0] PROT_RST = 8'hff;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

  // configuration byte addresses fetched during the reset sequence
  localparam logic [15:0] CFG_ADDR_BLK0 = 16'hff0d;
  localparam logic [15:0] CFG_ADDR_BLK1 = 16'hff0c;

  // fixed range bounds, unpaged and paged: high range ends, low range starts
  localparam logic [15:0] HI_END = 16'hffff;
  localparam logic [15:0] HI_PG_END = 16'hcfff;
  localparam logic [15:0] LO_START = 16'h4000;
  localparam logic [15:0] LO_PG_START = 16'h8000;

  // mirror pages
  localparam logic [7:0] PG_HI_A = 8'h37;
  localparam logic [7:0] PG_HI_B = 8'h3f;
  localparam logic [7:0] PG_LO_A = 8'h36;
  localparam logic [7:0] PG_LO_B = 8'h3e;

  // allowed scenario transitions: bit n of entry m allows m to n
  localparam logic [63:0] SCEN_ALLOW = 64'hff5a_3c18_080c_0a0f;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // reset sequence states
  typedef enum logic [1:0] {LOAD_BLK0, LOAD_BLK1, LOAD_LAST, RUN} seq_type;

endpackage

// file: src/prot_range_check.sv
// address range decode for one flash block against its protection byte
`timescale 1ns/1ps
module prot_range_check
  import flash_prot_pkg::*;
(
  // protection setting
  input wire logic [7:0] prot_i,
  // target address
  input wire logic [15:0] addr_i,
  input wire logic [7:0] page_i,
  input wire logic paged_i,
  // results
  output logic prot_hit_o,
  output logic any_prot_o
);

  logic [15:0] hi_start; // first address of high range
  logic [15:0] lo_end; // last address of low range
  logic hit_hi; // address within the high range
  logic hit_lo; // address within the low range
  logic act_hi; // high range region present
  logic act_lo; // low range region present

  // range sizes from the size fields, paged mirrors included
  always_comb begin
    if (paged_i) begin
      case (prot_i[POS_HS_HI:POS_HS_LO]) // see R11
        2'b00: hi_start = 16'hc800;
        2'b01: hi_start = 16'hc000;
        2'b10: hi_start = 16'hb000;
        default: hi_start = 16'h8000;
      endcase
      case (prot_i[POS_LS_HI:POS_LS_LO]) // see R12
        2'b00: lo_end = 16'h83ff;
        2'b01: lo_end = 16'h87ff;
        2'b10: lo_end = 16'h8fff;
        default: lo_end = 16'h9fff;
      endcase
      hit_hi = (page_i == PG_HI_A || page_i == PG_HI_B) &&
               addr_i >= hi_start && addr_i <= HI_PG_END;
      hit_lo = (page_i == PG_LO_A || page_i == PG_LO_B) &&
               addr_i >= LO_PG_START && addr_i <= lo_end;
    end else begin
      case (prot_i[POS_HS_HI:POS_HS_LO]) // see R11
        2'b00: hi_start = 16'hf800;
        2'b01: hi_start = 16'hf000;
        2'b10: hi_start = 16'he000;
        default: hi_start = 16'hc000;
      endcase
      case (prot_i[POS_LS_HI:POS_LS_LO]) // see R12
        2'b00: lo_end = 16'h43ff;
        2'b01: lo_end = 16'h47ff;
        2'b10: lo_end = 16'h4fff;
        default: lo_end = 16'h5fff;
      endcase
      hit_hi = addr_i >= hi_start && addr_i <= HI_END;
      hit_lo = addr_i >= LO_START && addr_i <= lo_end;
    end
  end

  // disable bits remove a region, function bit flips its meaning
  assign act_hi = !prot_i[POS_HDIS]; // see R06
  assign act_lo = !prot_i[POS_LDIS]; // see R07

  // protected when inside an enabled range, or outside all open ones
  assign prot_hit_o = prot_i[POS_FUNC] ?
                      ((act_hi && hit_hi) || (act_lo && hit_lo)) :
                      !((act_hi && hit_hi) || (act_lo && hit_lo)); // see R05 see R10

  // only scenario 7 leaves every sector open
  assign any_prot_o = !(prot_i[POS_FUNC] && prot_i[POS_HDIS] && prot_i[POS_LDIS]); // see R10

endmodule

// file: src/flash_sector_protection.sv
// flash sector protection registers, range checking and axi4-lite slave
//
// Functional notes
// R01 - reset loads block bytes from 0xFF0D, 0xFF0C
// R02 - reserved bit 6 read-only, kept at one; here it keeps bit 6 of the configuration byte loaded at reset
// R03 - protected program or erase sets violation flag
// R04 - mass erase refused while any sector protected; here only protected sectors of the block named by cmd_block_i refuse it
// R05 - bit 7 selects protected or unprotected ranges
// R06 - bit 5 zero enables the high region
// R07 - bit 2 zero enables the low region
// R08 - high size writable only while high disabled
// R09 - low size writable only while low disabled
// R10 - three control bits decode eight scenarios
// R11 - high range sizes 2 to 16 KB; paged size 11 here spans 0x8000 to 0xCFFF, 20 KB
// R12 - low range sizes 1 to 8 KB
// R13 - disallowed transition write leaves register unchanged
// R14 - only listed scenario transitions are permitted
// R15 - reads return the enforced protection scenario
// R16 - software unprotects upper sector before reprogramming byte
// R17 - scenario number is function, high, low bits
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module flash_sector_protection
  import flash_prot_pkg::*;
#(
  parameter int NBLK = 2
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // axi4-lite write address
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  // axi4-lite write data
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // axi4-lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read address
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  // axi4-lite read data
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // configuration byte fetch during reset sequence
  output logic cfg_rd_en_o,
  output logic [15:0] cfg_rd_addr_o,
  input wire logic [7:0] cfg_rd_data_i,
  // command check from the sequencer
  input wire logic cmd_valid_i,
  input wire logic cmd_mass_i,
  input wire logic cmd_block_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic cmd_paged_i,
  output logic cmd_refuse_o,
  // status and interrupt
  output logic ready_o,
  output logic [NBLK-1:0] violation_o,
  output logic irq_o
);

  // scenario number from function, high disable and low disable bits
  function automatic logic [2:0] scen_of(input logic [7:0] p);
    scen_of = {p[POS_FUNC], p[POS_HDIS], p[POS_LDIS]}; // see R17
  endfunction

  // transition check against the allowed table
  function automatic logic scen_ok(input logic [2:0] from, input logic [2:0] to);
    scen_ok = SCEN_ALLOW[{from, to}]; // see R14
  endfunction

  // register decode by word index
  function automatic logic [7:0] idx_of(input logic [7:0] a);
    idx_of = {2'b00, a[7:2]};
  endfunction

  // reset sequence state
  seq_type seq_r, seq_nxt;
  // banked protection registers
  logic [7:0] prot_r [NBLK];
  logic [7:0] prot_nxt [NBLK];
  // selected bank
  logic bank_r, bank_nxt;
  // sticky events and their enables
  logic [EVT_W-1:0] evt_r, evt_nxt;
  logic [EVT_W-1:0] evt_en_r, evt_en_nxt;
  // write channel capture
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  // read channel
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // range results per block
  logic [NBLK-1:0] hit;
  logic [NBLK-1:0] any_prot;
  // event pulses from the command check
  logic [EVT_W-1:0] evt_set;
  // write commit strobe
  logic wr_fire;
  logic run;

  assign run = (seq_r == RUN);

  // one range checker per flash block
  genvar g;
  generate
    for (g = 0; g < NBLK; g++) begin : g_blk
      prot_range_check u_chk (
        .prot_i(prot_r[g]),
        .addr_i(cmd_addr_i),
        .page_i(cmd_page_i),
        .paged_i(cmd_paged_i),
        .prot_hit_o(hit[g]),
        .any_prot_o(any_prot[g])
      );
    end
  endgenerate

  // refuse a protected target or a mass erase of a protected block
  always_comb begin
    evt_set = '0;
    cmd_refuse_o = 1'b0;
    if (cmd_valid_i && run) begin
      if (cmd_mass_i && any_prot[cmd_block_i]) begin // see R04
        cmd_refuse_o = 1'b1;
        evt_set[EVT_MASS0 + 32'(cmd_block_i)] = 1'b1;
      end else if (!cmd_mass_i && hit[cmd_block_i]) begin
        cmd_refuse_o = 1'b1;
        evt_set[EVT_VIOL0 + 32'(cmd_block_i)] = 1'b1; // see R03
      end
    end
  end

  // config fetch walks both bytes, data one cycle after the address
  always_comb begin
    seq_nxt = seq_r;
    cfg_rd_en_o = 1'b0;
    cfg_rd_addr_o = CFG_ADDR_BLK0;
    case (seq_r)
      LOAD_BLK0: begin
        cfg_rd_en_o = 1'b1;
        cfg_rd_addr_o = CFG_ADDR_BLK0; // see R01
        seq_nxt = LOAD_BLK1;
      end
      LOAD_BLK1: begin
        cfg_rd_en_o = 1'b1;
        cfg_rd_addr_o = CFG_ADDR_BLK1; // see R01
        seq_nxt = LOAD_LAST;
      end
      LOAD_LAST: seq_nxt = RUN;
      default: seq_nxt = RUN;
    endcase
  end

  // write side handshake, both channels in either order
  assign awready_o = run && !aw_got_r && !bvalid_r;
  assign wready_o = run && !w_got_r && !bvalid_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (awvalid_i && awready_o) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      w_got_nxt = 1'b1;
      w_data_nxt = wdata_i;
      w_strb_nxt = wstrb_i;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (idx_of(aw_addr_r) == IDX_PROT || idx_of(aw_addr_r) == IDX_STAT ||
          idx_of(aw_addr_r) == IDX_BANK || idx_of(aw_addr_r) == IDX_EVT_STAT ||
          idx_of(aw_addr_r) == IDX_EVT_CLR || idx_of(aw_addr_r) == IDX_EVT_EN) begin
        bresp_nxt = RESP_OKAY;
      end else begin
        bresp_nxt = RESP_SLVERR; // unmapped
      end
    end else if (bvalid_r && bready_i) begin
      bvalid_nxt = 1'b0;
    end
  end

  // protection register loading and guarded software writes
  always_comb begin
    logic [7:0] cur;
    logic [7:0] cand;
    cur = prot_r[bank_r];
    cand = cur;
    for (int i = 0; i < NBLK; i++) begin
      prot_nxt[i] = prot_r[i];
    end
    bank_nxt = bank_r;
    if (seq_r == LOAD_BLK1) begin
      prot_nxt[0] = cfg_rd_data_i; // see R01
    end else if (seq_r == LOAD_LAST) begin
      prot_nxt[1] = cfg_rd_data_i; // see R01
    end else if (wr_fire && w_strb_r[0]) begin
      if (idx_of(aw_addr_r) == IDX_PROT) begin
        cand[POS_FUNC] = w_data_r[POS_FUNC];
        cand[POS_RSV] = cur[POS_RSV]; // see R02
        cand[POS_HDIS] = w_data_r[POS_HDIS];
        cand[POS_LDIS] = w_data_r[POS_LDIS];
        if (cur[POS_HDIS]) begin
          cand[POS_HS_HI:POS_HS_LO] = w_data_r[POS_HS_HI:POS_HS_LO]; // see R08
        end
        if (cur[POS_LDIS]) begin
          cand[POS_LS_HI:POS_LS_LO] = w_data_r[POS_LS_HI:POS_LS_LO]; // see R09
        end
        // whole write dropped on a disallowed scenario change
        if (scen_ok(scen_of(cur), scen_of(cand))) begin // see R13 see R14
          prot_nxt[bank_r] = cand;
        end
      end else if (idx_of(aw_addr_r) == IDX_BANK) begin
        bank_nxt = w_data_r[0];
      end
    end
  end

  // sticky events, set wins over a simultaneous clear
  always_comb begin
    evt_nxt = evt_r;
    evt_en_nxt = evt_en_r;
    if (wr_fire && w_strb_r[0]) begin
      if (idx_of(aw_addr_r) == IDX_EVT_CLR) begin
        evt_nxt = evt_r & ~w_data_r[EVT_W-1:0];
      end else if (idx_of(aw_addr_r) == IDX_EVT_EN) begin
        evt_en_nxt = w_data_r[EVT_W-1:0];
      end
    end
    evt_nxt = evt_nxt | evt_set; // see R03
  end

  // read side, one outstanding read answered one cycle after address
  assign arready_o = run && !rvalid_r;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (arvalid_i && arready_o) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (idx_of(araddr_i) == IDX_PROT) begin
        rdata_nxt[7:0] = prot_r[bank_r]; // see R15
      end else if (idx_of(araddr_i) == IDX_STAT) begin
        rdata_nxt[POS_VIOL] = evt_r[EVT_VIOL0 + 32'(bank_r)]; // see R03
      end else if (idx_of(araddr_i) == IDX_BANK) begin
        rdata_nxt[0] = bank_r;
      end else if (idx_of(araddr_i) == IDX_EVT_STAT) begin
        rdata_nxt[EVT_W-1:0] = evt_r;
      end else if (idx_of(araddr_i) == IDX_EVT_CLR) begin
        rdata_nxt[EVT_W-1:0] = '0; // write-only, reads zero
      end else if (idx_of(araddr_i) == IDX_EVT_EN) begin
        rdata_nxt[EVT_W-1:0] = evt_en_r;
      end else begin
        rresp_nxt = RESP_SLVERR; // unmapped
      end
    end else if (rvalid_r && rready_i) begin
      rvalid_nxt = 1'b0;
    end
  end

  // state registers; protection starts open until the bytes arrive
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_r <= LOAD_BLK0;
      for (int i = 0; i < NBLK; i++) begin
        prot_r[i] <= PROT_RST;
      end
      bank_r <= 1'b0;
      evt_r <= EVT_RST;
      evt_en_r <= EVT_RST;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      seq_r <= seq_nxt;
      for (int i = 0; i < NBLK; i++) begin
        prot_r[i] <= prot_nxt[i];
      end
      bank_r <= bank_nxt;
      evt_r <= evt_nxt;
      evt_en_r <= evt_en_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // outputs
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;
  assign ready_o = run;
  assign violation_o = evt_r[EVT_VIOL0 +: NBLK];
  assign irq_o = |(evt_r & evt_en_r);

endmodule

// file: dv/flash_prot_asserts.sv
// property checker for the flash sector protection block
`timescale 1ns/1ps
module flash_prot_asserts
  import flash_prot_pkg::*;
#(
  parameter int NBLK = 2
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // configuration fetch
  input wire logic cfg_rd_en_o,
  input wire logic [15:0] cfg_rd_addr_o,
  // command check
  input wire logic cmd_valid_i,
  input wire logic cmd_mass_i,
  input wire logic cmd_block_i,
  input wire logic cmd_refuse_o,
  // status
  input wire logic ready_o,
  input wire logic [NBLK-1:0] violation_o,
  input wire logic irq_o,
  // read data
  input wire logic rvalid_o,
  input wire logic [31:0] rdata_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // block 0 byte is fetched before block 1
  // sampled reset keeps the release edge itself out, the state holds there
  a_fetch_order: assert property (
    reset_n_i && cfg_rd_en_o && cfg_rd_addr_o == CFG_ADDR_BLK0 |=>
    cfg_rd_addr_o == CFG_ADDR_BLK1)
    else $error("config fetch order wrong");
  // ready two edges after the block 1 address
  a_fetch_done: assert property (
    cfg_rd_en_o && cfg_rd_addr_o == CFG_ADDR_BLK1 |-> ##2 ready_o)
    else $error("ready late after fetch");
  // once running, stays running until reset
  a_ready_holds: assert property (ready_o |=> ready_o)
    else $error("ready dropped");
  a_no_fetch_run: assert property (ready_o |-> !cfg_rd_en_o)
    else $error("fetch while running");
  // nothing refused before protection bytes are loaded
  a_refuse_idle: assert property (!ready_o |-> !cmd_refuse_o)
    else $error("refuse before ready");
  a_viol_sets: assert property (
    ready_o && cmd_valid_i && cmd_refuse_o && !cmd_mass_i |=> violation_o[$past(cmd_block_i)])
    else $error("violation flag not set");
  a_viol_cause: assert property (
    $rose(violation_o[0]) |-> $past(cmd_valid_i) && $past(cmd_refuse_o) && !$past(cmd_block_i))
    else $error("violation flag without cause");
  // a refused mass erase is not a program violation
  a_mass_no_viol: assert property (
    cmd_valid_i && cmd_mass_i && !cmd_block_i && !violation_o[0] |=> !violation_o[0])
    else $error("mass erase set violation");
  a_read_pad: assert property (rvalid_o |-> rdata_o[31:8] == 24'h00_0000)
    else $error("read upper bits not zero");

  c_viol: cover property ($rose(violation_o[1]));
  c_mass: cover property (cmd_valid_i && cmd_mass_i && cmd_refuse_o);
  c_irq: cover property ($rose(irq_o));
endmodule

// file: dv/cfg_byte_source.sv
// far-side model: nonvolatile configuration bytes fetched at reset
`timescale 1ns/1ps
module cfg_byte_source
  import flash_prot_pkg::*;
#(
  parameter logic [7:0] BYTE_BLK0 = 8'hdf,
  parameter logic [7:0] BYTE_BLK1 = 8'h7b
) (
  // clock
  input wire logic ref_clk_i,
  // fetch request from the block
  input wire logic cfg_rd_en_i,
  input wire logic [15:0] cfg_rd_addr_i,
  output logic [7:0] cfg_data_o
);
  logic [7:0] data_r = 8'h5a; // byte on the data lines, arbitrary start

  // answer one cycle after the address, when the block samples it;
  // idle lines show the inverse so stale data never passes as a fresh byte
  always_ff @(posedge ref_clk_i) begin
    if (cfg_rd_en_i && cfg_rd_addr_i == CFG_ADDR_BLK0) begin
      data_r <= BYTE_BLK0;
    end else if (cfg_rd_en_i && cfg_rd_addr_i == CFG_ADDR_BLK1) begin
      data_r <= BYTE_BLK1;
    end else begin
      data_r <= ~data_r;
    end
  end

  assign cfg_data_o = data_r;
endmodule

// file: dv/flash_sector_protection_test.sv
// self-checking bench for the flash sector protection block
`timescale 1ns/1ps
module flash_sector_protection_test import flash_prot_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, arvalid_i = 1'b0, bready_i = 1'b1, rready_i = 1'b1;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00, cfg_rd_data_i, cmd_page_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [3:0] wstrb_i = 4'h1;
  logic cmd_valid_i = 1'b0, cmd_mass_i = 1'b0, cmd_block_i = 1'b0, cmd_paged_i = 1'b0;
  logic [15:0] cmd_addr_i = 16'h0000, cfg_rd_addr_o;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, cfg_rd_en_o, cmd_refuse_o;
  logic ready_o, irq_o;
  logic [1:0] bresp_o, rresp_o, violation_o;
  logic [31:0] rdata_o, rd;
  logic [1:0] rs; // last response code
  int err_total = 0, checks_done = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  flash_sector_protection #(.NBLK(2)) uut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .cfg_rd_en_o(cfg_rd_en_o), .cfg_rd_addr_o(cfg_rd_addr_o), .cfg_rd_data_i(cfg_rd_data_i),
    .cmd_valid_i(cmd_valid_i), .cmd_mass_i(cmd_mass_i), .cmd_block_i(cmd_block_i),
    .cmd_addr_i(cmd_addr_i), .cmd_page_i(cmd_page_i), .cmd_paged_i(cmd_paged_i),
    .cmd_refuse_o(cmd_refuse_o), .ready_o(ready_o), .violation_o(violation_o),
    .irq_o(irq_o));
  // block 0 scenario 5 high 16K, block 1 scenario 2 low 8K open
  cfg_byte_source far (.ref_clk_i(ref_clk_i), .cfg_rd_en_i(cfg_rd_en_o),
    .cfg_rd_addr_i(cfg_rd_addr_o), .cfg_data_o(cfg_rd_data_i));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr_i <= a;
    wdata_i <= {24'h00_0000, d};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    forever begin
      @(posedge ref_clk_i);
      if (!aw && !w && bvalid_o === 1'b1) begin
        rs = bresp_o;
        break;
      end
      aw = aw && awready_o !== 1'b1;
      w = w && wready_o !== 1'b1;
      awvalid_i <= aw;
      wvalid_i <= w;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what,
      input logic [31:0] m = 32'hffff_ffff);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    @(posedge ref_clk_i);
    while (arready_o !== 1'b1) @(posedge ref_clk_i);
    arvalid_i <= 1'b0;
    @(posedge ref_clk_i);
    while (rvalid_o !== 1'b1) @(posedge ref_clk_i);
    rd = rdata_o;
    rs = rresp_o;
    chk(what, exp, rd & m);
  endtask

  // valid stays high across calls, each cycle is one attempt
  task automatic cmd(input logic b, input logic m, input logic p, input logic [7:0] pg,
      input logic [15:0] a, input logic e);
    {cmd_valid_i, cmd_block_i, cmd_mass_i, cmd_paged_i, cmd_page_i, cmd_addr_i} <=
      {1'b1, b, m, p, pg, a};
    @(negedge ref_clk_i);
    chk("cmd_refuse_o", {31'h0000_0000, e}, {31'h0000_0000, cmd_refuse_o});
    @(posedge ref_clk_i);
  endtask

  task automatic conclude();
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog well beyond the hundred or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    while (ready_o !== 1'b1) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    rchk(8'h10, 32'hdf, "prot blk0");
    wr(8'h18, 8'h01);
    rchk(8'h10, 32'h7b, "prot blk1");
    wr(8'h18, 8'h00);
    rchk(8'h3c, 32'h0, "unmapped data");
    chk("unmapped rresp", RESP_SLVERR, rs);
    wr(8'h28, 8'h00);
    cmd(1'b0, 1'b0, 1'b0, 8'h00, 16'hc000, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 8'h00, 16'hff0d, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 8'h00, 16'hbfff, 1'b0);
    cmd(1'b0, 1'b0, 1'b1, 8'h3f, 16'h8000, 1'b1);
    cmd(1'b0, 1'b0, 1'b1, 8'h36, 16'h8000, 1'b0);
    cmd(1'b1, 1'b0, 1'b0, 8'h00, 16'h5fff, 1'b0);
    cmd(1'b1, 1'b0, 1'b0, 8'h00, 16'h6000, 1'b1);
    cmd(1'b1, 1'b0, 1'b1, 8'h3e, 16'h9fff, 1'b0);
    cmd(1'b1, 1'b0, 1'b1, 8'h3e, 16'ha000, 1'b1);
    cmd(1'b0, 1'b1, 1'b0, 8'h00, 16'h0000, 1'b1);
    cmd(1'b1, 1'b1, 1'b0, 8'h00, 16'h0000, 1'b1);
    cmd_valid_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("violation_o", 32'h3, {30'h0000_0000, violation_o});
    rchk(8'h14, 32'h20, "status viol", 32'h20);
    rchk(8'h20, 32'hf, "event status");
    chk("irq masked", 32'h0, {31'h0000_0000, irq_o});
    wr(8'h28, 8'h01);
    chk("irq enabled", 32'h1, {31'h0000_0000, irq_o});
    wr(8'h24, 8'h01);
    chk("irq cleared", 32'h0, {31'h0000_0000, irq_o});
    rchk(8'h20, 32'he, "event after clear");
    wr(8'h24, 8'h0e);
    rchk(8'h20, 32'h0, "event all cleared");
    cmd(1'b0, 1'b1, 1'b0, 8'h00, 16'h0000, 1'b1);
    cmd_valid_i <= 1'b0;
    rchk(8'h20, 32'h4, "event mass only");
    wr(8'h10, 8'hff);
    rchk(8'h10, 32'hdf, "prot 5 to 7");
    wr(8'h10, 8'h81);
    rchk(8'h10, 32'hd9, "prot 5 to 4");
    cmd(1'b0, 1'b0, 1'b0, 8'h00, 16'h47ff, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 8'h00, 16'h4800, 1'b0);
    cmd_valid_i <= 1'b0;
    wr(8'h10, 8'hdd);
    rchk(8'h10, 32'hd9, "prot 4 to 5");
    wr(8'h10, 8'h7f);
    rchk(8'h10, 32'h7d, "prot 4 to 3");
    cmd(1'b0, 1'b0, 1'b0, 8'h00, 16'h8000, 1'b1);
    cmd_valid_i <= 1'b0;
    // second reset in mid-run reloads the configuration bytes
    reset_n_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    while (ready_o !== 1'b1) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    chk("violation after reset", 32'h0, {30'h0000_0000, violation_o});
    rchk(8'h10, 32'hdf, "prot reload");
    wr(8'h3c, 8'h00);
    chk("unmapped bresp", RESP_SLVERR, rs);
    conclude();
  end
endmodule

bind flash_sector_protection flash_prot_asserts #(.NBLK(NBLK)) chk_inst (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cfg_rd_en_o(cfg_rd_en_o),
  .cfg_rd_addr_o(cfg_rd_addr_o), .cmd_valid_i(cmd_valid_i), .cmd_mass_i(cmd_mass_i),
  .cmd_block_i(cmd_block_i), .cmd_refuse_o(cmd_refuse_o), .ready_o(ready_o),
  .violation_o(violation_o), .irq_o(irq_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o));
